// file: logic/lnb_status_pkg.sv
// constants and types shared by the fault/status core and its serial link
package lnb_status_pkg;

  localparam int unsigned CORE_CLK_KHZ = 10000;
  localparam int unsigned CNT_W        = 24;

  // times in their own units, cycle counts derived from the core clock rate
  localparam int unsigned RETRY_MS     = 1000;
  localparam int unsigned RETRY_CYC    = RETRY_MS * CORE_CLK_KHZ;
  localparam int unsigned EPF_DLY1_US  = 11500;
  localparam int unsigned EPF_DLY2_US  = 46000;
  localparam int unsigned EPF_DLY3_US  = 92000;
  localparam int unsigned EPF_DLY1_CYC = EPF_DLY1_US * CORE_CLK_KHZ / 1000;
  localparam int unsigned EPF_DLY2_CYC = EPF_DLY2_US * CORE_CLK_KHZ / 1000;
  localparam int unsigned EPF_DLY3_CYC = EPF_DLY3_US * CORE_CLK_KHZ / 1000;
  // overcurrent disable time: plain default, set per product
  localparam int unsigned TDIS_US      = 100;
  localparam int unsigned TDIS_CYC     = TDIS_US * CORE_CLK_KHZ / 1000;

  // serial slave address: arbitrary value
  localparam logic [6:0] DEV_ADDR_DEF = 7'h08;

  // register offsets and status reset value
  localparam logic [7:0] STATUS0_OFS = 8'h00;
  localparam logic [7:0] STATUS1_OFS = 8'h01;
  localparam logic [7:0] STATUS_RST  = 8'h00;

  // status byte 0 field positions
  localparam int unsigned S0_OFF_LSB   = 0;
  localparam int unsigned S0_OC_LSB    = 2;
  localparam int unsigned S0_PBAD_LSB  = 4;
  localparam int unsigned S0_UV_BIT    = 6;
  localparam int unsigned S0_THERM_BIT = 7;
  // status byte 1 field positions
  localparam int unsigned S1_PUMP_LSB  = 0;
  localparam int unsigned S1_TONE_LSB  = 2;
  localparam int unsigned S1_EPF_BIT   = 4;
  localparam int unsigned S1_LOCK_BIT  = 5;
  localparam int unsigned S1_BOOST_LSB = 6;

  // fail-delay select codes
  localparam logic [1:0] EPF_SEL_NONE = 2'h0;
  localparam logic [1:0] EPF_SEL_1    = 2'h1;
  localparam logic [1:0] EPF_SEL_2    = 2'h2;

  typedef enum logic [6:0] {
    LS_IDLE = 7'h01,
    LS_ADDR = 7'h02,
    LS_AACK = 7'h04,
    LS_PTR  = 7'h08,
    LS_PACK = 7'h10,
    LS_TX   = 7'h20,
    LS_TACK = 7'h40
  } link_state_t;

endpackage

// file: logic/status_serial_link.sv
// two-wire serial slave for the status bytes, clocked by the host's serial clock
`timescale 1ns/10ps
module status_serial_link
  import lnb_status_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEF
) (
  input  wire logic       scl_i,
  input  wire logic       rst_n_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  input  wire logic [7:0] status0_i,
  input  wire logic [7:0] status1_i,
  input  wire logic       snap_req_i,
  output logic            snap_ack_o,
  output logic            read_done_tgl_o
);

  link_state_t st_q, st_d;
  logic [3:0]  cnt_q, cnt_d;
  logic [7:0]  sh_q, sh_d, tx_q, tx_d;
  logic [15:0] snap_q, snap_d;
  logic        rw_q, rw_d, ptr_q, ptr_d, done_q, done_d, ack_q, ack_d;
  logic        sda_pos_q, sda_pos_d, start_q, start_d, oe_q, oe_d;
  logic        rst_s1_q, rst_s2_q, req_s1_q, req_s2_q;

  function automatic logic [7:0] pick(input logic p, input logic [15:0] s);
    pick = p ? s[15:8] : s[7:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // reset and snapshot request crossings; the link clock only runs in frames
  always_ff @(posedge scl_i) begin
    rst_s1_q <= rst_n_i;
    rst_s2_q <= rst_s1_q;
    req_s1_q <= snap_req_i;
    req_s2_q <= req_s1_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // rising edge: sample data, walk the byte protocol
  always_comb begin
    st_d      = st_q;
    cnt_d     = cnt_q;
    sh_d      = {sh_q[6:0], sda_i};
    rw_d      = rw_q;
    ptr_d     = ptr_q;
    tx_d      = tx_q;
    done_d    = done_q;
    snap_d    = snap_q;
    ack_d     = ack_q;
    sda_pos_d = sda_i;
    if (req_s2_q != ack_q) begin
      snap_d = {status1_i, status0_i};
      ack_d  = ~ack_q;
    end
    if (start_q) begin
      st_d  = LS_ADDR;
      cnt_d = 4'h1;
      sh_d  = {7'h00, sda_i};
    end else begin
      case (st_q)
        LS_IDLE: st_d = LS_IDLE;
        LS_ADDR: begin
          cnt_d = cnt_q + 4'h1;
          if (cnt_q == 4'h7) begin
            rw_d = sh_d[0];
            st_d = (sh_d[7:1] == DEV_ADDR) ? LS_AACK : LS_IDLE;
          end
        end
        LS_AACK: begin
          cnt_d = 4'h0;
          if (rw_q) begin
            st_d = LS_TX;
            tx_d = pick(ptr_q, snap_q);
          end else begin
            st_d = LS_PTR;
          end
        end
        LS_PTR: begin
          cnt_d = cnt_q + 4'h1;
          if (cnt_q == 4'h7) begin
            ptr_d = sh_d[0];
            st_d  = LS_PACK;
          end
        end
        LS_PACK: begin
          cnt_d = 4'h0;
          st_d  = LS_PTR;
        end
        LS_TX: begin
          cnt_d = cnt_q + 4'h1;
          if (cnt_q == 4'h7) begin
            st_d = LS_TACK;
          end
        end
        LS_TACK: begin
          cnt_d = 4'h0;
          if (sda_i) begin
            // host ends an acknowledged read with a not-acknowledge
            done_d = ~done_q;
            st_d   = LS_IDLE;
          end else begin
            ptr_d = ~ptr_q;
            tx_d  = pick(~ptr_q, snap_q);
            st_d  = LS_TX;
          end
        end
        default: st_d = LS_IDLE;
      endcase
    end
  end

  always_ff @(posedge scl_i) begin
    if (!rst_s2_q) begin
      st_q      <= LS_IDLE;
      cnt_q     <= 4'h0;
      sh_q      <= 8'h00;
      rw_q      <= 1'b0;
      ptr_q     <= 1'b0;
      tx_q      <= 8'h00;
      done_q    <= 1'b0;
      snap_q    <= 16'h0000;
      ack_q     <= 1'b0;
      sda_pos_q <= 1'b1;
    end else begin
      st_q      <= st_d;
      cnt_q     <= cnt_d;
      sh_q      <= sh_d;
      rw_q      <= rw_d;
      ptr_q     <= ptr_d;
      tx_q      <= tx_d;
      done_q    <= done_d;
      snap_q    <= snap_d;
      ack_q     <= ack_d;
      sda_pos_q <= sda_pos_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // falling edge: data falling while the clock was high marks a start; drive data
  always_comb begin
    start_d = sda_pos_q & ~sda_i;
    case (st_q)
      LS_AACK, LS_PACK: oe_d = 1'b1;
      LS_TX:            oe_d = ~tx_q[3'h7 - cnt_q[2:0]];
      default:          oe_d = 1'b0;
    endcase
  end

  always_ff @(negedge scl_i) begin
    if (!rst_s2_q) begin
      start_q <= 1'b0;
      oe_q    <= 1'b0;
    end else begin
      start_q <= start_d;
      oe_q    <= oe_d;
    end
  end

  assign sda_o           = 1'b0;
  assign sda_oe_o        = oe_q;
  assign snap_ack_o      = ack_q;
  assign read_done_tgl_o = done_q;

endmodule

// file: logic/lnb_fault_status_irq.sv
// fault and status flags, interrupt line and auto-retry for a two-channel supply
// Summary of operation
// - output-off set when channel disabled or undervolt, overcurrent, pump or thermal fault.
// - pump-ok reads 0 on low pump voltage, which also forces output-off.
// - overcurrent flag sets after overload outlasts the disable time; forces output-off.
// - while enabled, power-bad sets outside 9% window, clears back inside 5%.
// - tone seen uses transmit threshold when tone-select is 1, receive when 0.
// - overtemperature sets thermal flag and output-off on both channels.
// - input or regulator low voltage sets undervolt flag and output-off flags.
// - boost-high follows 23.7 V set, 23.6 V clear; never touches the interrupt.
// - fail warning sets early-fail flag, pulls interrupt; clears after delay on recovery.
// - fail-clear delay select: 00 none, 01 11.5 ms, 10 46 ms, 11 92 ms.
// - status byte 0 at 0x00: off, overcurrent, power-bad, undervolt, thermal.
// - output-off stays set until channel enabled again with no fault.
// - restart policy 1: overcurrent retried each 1 s, cleared only if overload gone.
// - restart policy 1: thermal retried each 1 s, cleared only once cool.
// - restart policy 0: overcurrent and thermal latched until read after fault gone.
// - undervolt stays latched until a read with supply back above 9.0 V.
// - interrupt low on overcurrent, undervolt or thermal set; released by next read.
// - power-bad is unlatched and never affects the interrupt.
`timescale 1ns/10ps
module lnb_fault_status_irq
  import lnb_status_pkg::*;
#(
  parameter int unsigned RETRY_CYCLES = RETRY_CYC,
  parameter int unsigned EPF_CYCLES1  = EPF_DLY1_CYC,
  parameter int unsigned EPF_CYCLES2  = EPF_DLY2_CYC,
  parameter int unsigned EPF_CYCLES3  = EPF_DLY3_CYC,
  parameter int unsigned TDIS_CYCLES  = TDIS_CYC,
  parameter logic [6:0]  DEV_ADDR     = DEV_ADDR_DEF
) (
  input  wire logic       core_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  input  wire logic       vin_low_i,
  input  wire logic       vreg_low_i,
  input  wire logic       overtemp_i,
  input  wire logic       fail_warn_i,
  input  wire logic       fail_recovered_i,
  input  wire logic [1:0] over_limit_i,
  input  wire logic [1:0] pump_low_i,
  input  wire logic [1:0] out_outside_wide_i,
  input  wire logic [1:0] out_inside_narrow_i,
  input  wire logic [1:0] tone_xmt_valid_i,
  input  wire logic [1:0] tone_rcv_valid_i,
  input  wire logic [1:0] boost_above_set_i,
  input  wire logic [1:0] boost_below_clr_i,
  input  wire logic [1:0] channel_on_bit_i,
  input  wire logic [1:0] tone_tx_select_i,
  input  wire logic       restart_policy_i,
  input  wire logic       fail_delay_sel_low_i,
  input  wire logic       fail_delay_sel_high_i,
  input  wire logic       factory_lock_flag_i,
  output logic [1:0]      output_off_flag_o,
  output logic [7:0]      status0_o,
  output logic [7:0]      status1_o,
  output logic            irq_n_o
);

  localparam int unsigned RAW_W = 21;

  logic [RAW_W-1:0] raw, s1_q, s2_q;
  logic vin_low_s, vreg_low_s, overtemp_s, fail_warn_s, fail_rec_s;
  logic [1:0] over_s, pump_low_s, far_s, near_s, txv_s, rxv_s, bst_up_s, bst_dn_s;

  logic [1:0] off_q, off_d, oc_q, oc_d, pbad_q, pbad_d, tone_q, tone_d;
  logic [1:0] pump_ok_q, pump_ok_d, bst_q, bst_d, oc_due;
  logic       uv_q, uv_d, therm_q, therm_d, epf_q, epf_d, irq_q, irq_d, set_evt;
  logic [CNT_W-1:0] oc_tmr_q [2];
  logic [CNT_W-1:0] oc_tmr_d [2];
  logic [CNT_W-1:0] retry_q, retry_d, epf_cnt_q, epf_cnt_d, epf_lim;
  logic       retry_tick, epf_due, uv_cond;

  logic [7:0] pub0_q, pub0_d, pub1_q, pub1_d;
  logic       req_q, req_d, ack_s1_q, ack_s2_q, dn_s1_q, dn_s2_q, dn_s3_q;
  logic       ack_tgl, done_tgl, read_done;

  function automatic logic reached(input logic [CNT_W-1:0] c, input int unsigned lim);
    reached = (c >= CNT_W'(lim));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // comparator inputs come from the analog side, unrelated to this clock
  assign raw = {vin_low_i, vreg_low_i, overtemp_i, fail_warn_i, fail_recovered_i,
                over_limit_i, pump_low_i, out_outside_wide_i, out_inside_narrow_i,
                tone_xmt_valid_i, tone_rcv_valid_i, boost_above_set_i, boost_below_clr_i};

  always_ff @(posedge core_clk_i) begin
    s1_q <= raw;
    s2_q <= s1_q;
  end

  assign {vin_low_s, vreg_low_s, overtemp_s, fail_warn_s, fail_rec_s, over_s, pump_low_s,
          far_s, near_s, txv_s, rxv_s, bst_up_s, bst_dn_s} = s2_q;

  ////////////////////////////////////////////////////////////////////////////
  // timers
  assign uv_cond    = vin_low_s | vreg_low_s;
  assign retry_tick = reached(retry_q, RETRY_CYCLES - 1);

  always_comb begin
    case ({fail_delay_sel_high_i, fail_delay_sel_low_i})
      EPF_SEL_NONE: epf_lim = '0;
      EPF_SEL_1:    epf_lim = CNT_W'(EPF_CYCLES1);
      EPF_SEL_2:    epf_lim = CNT_W'(EPF_CYCLES2);
      default:      epf_lim = CNT_W'(EPF_CYCLES3);
    endcase
    epf_due   = epf_cnt_q >= epf_lim;
    epf_cnt_d = (epf_q && fail_rec_s && !epf_due) ? epf_cnt_q + 1'b1 : '0;
    // retry clock only runs while an auto-restart fault is pending
    if (restart_policy_i && ((|oc_q) || therm_q) && !retry_tick) begin
      retry_d = retry_q + 1'b1;
    end else begin
      retry_d = '0;
    end
    for (int i = 0; i < 2; i++) begin
      oc_due[i]   = over_s[i] && reached(oc_tmr_q[i], TDIS_CYCLES);
      oc_tmr_d[i] = (over_s[i] && !oc_q[i] && !oc_due[i]) ? oc_tmr_q[i] + 1'b1 : '0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      retry_q     <= '0;
      epf_cnt_q   <= '0;
      oc_tmr_q[0] <= '0;
      oc_tmr_q[1] <= '0;
    end else begin
      retry_q     <= retry_d;
      epf_cnt_q   <= epf_cnt_d;
      oc_tmr_q[0] <= oc_tmr_d[0];
      oc_tmr_q[1] <= oc_tmr_d[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flags; a setting condition beats a clear in the same cycle, except power-bad, which a disabled channel clears
  always_comb begin
    uv_d    = uv_cond || (uv_q && !read_done);
    therm_d = overtemp_s || (therm_q && !(restart_policy_i ? retry_tick : read_done));
    epf_d   = fail_warn_s || (epf_q && !(fail_rec_s && epf_due));
    for (int i = 0; i < 2; i++) begin
      oc_d[i] = oc_due[i] ||
                (oc_q[i] && !((restart_policy_i ? retry_tick : read_done) && !over_s[i]));
      pump_ok_d[i] = ~pump_low_s[i];
      // disabled channel: latch off until enabled with no fault left
      off_d[i] = !channel_on_bit_i[i] || uv_q || oc_q[i] || pump_low_s[i] || therm_q ||
                 (off_q[i] && !channel_on_bit_i[i]);
      if (!channel_on_bit_i[i]) begin
        pbad_d[i] = 1'b0;
      end else if (far_s[i]) begin
        pbad_d[i] = 1'b1;
      end else if (near_s[i]) begin
        pbad_d[i] = 1'b0;
      end else begin
        pbad_d[i] = pbad_q[i];
      end
      tone_d[i] = tone_tx_select_i[i] ? txv_s[i] : rxv_s[i];
      bst_d[i]  = bst_up_s[i] || (bst_q[i] && !bst_dn_s[i]);
    end
    // new overcurrent, undervolt, thermal or early-fail events pull the line
    set_evt = (|(oc_d & ~oc_q)) || (uv_d && !uv_q) || (therm_d && !therm_q) ||
              (epf_d && !epf_q);
    irq_d   = set_evt || (irq_q && !read_done);
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      uv_q      <= 1'b0;
      therm_q   <= 1'b0;
      epf_q     <= 1'b0;
      oc_q      <= 2'h0;
      pump_ok_q <= 2'h3;
      off_q     <= 2'h3;
      pbad_q    <= 2'h0;
      tone_q    <= 2'h0;
      bst_q     <= 2'h0;
      irq_q     <= 1'b0;
    end else begin
      uv_q      <= uv_d;
      therm_q   <= therm_d;
      epf_q     <= epf_d;
      oc_q      <= oc_d;
      pump_ok_q <= pump_ok_d;
      off_q     <= off_d;
      pbad_q    <= pbad_d;
      tone_q    <= tone_d;
      bst_q     <= bst_d;
      irq_q     <= irq_d;
    end
  end

  assign output_off_flag_o = off_q;
  assign irq_n_o           = ~irq_q;
  assign status0_o         = {therm_q, uv_q, pbad_q, oc_q, off_q};
  assign status1_o         = {bst_q, factory_lock_flag_i, epf_q, tone_q, pump_ok_q};

  ////////////////////////////////////////////////////////////////////////////
  // hand status to the link by a toggle handshake; published bytes hold still
  // until the link acknowledges, so the link reads a coherent pair
  always_comb begin
    pub0_d = pub0_q;
    pub1_d = pub1_q;
    req_d  = req_q;
    if (ack_s2_q == req_q) begin
      pub0_d = status0_o;
      pub1_d = status1_o;
      req_d  = ~req_q;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      pub0_q <= STATUS_RST;
      pub1_q <= STATUS_RST;
      req_q  <= 1'b0;
    end else begin
      pub0_q <= pub0_d;
      pub1_q <= pub1_d;
      req_q  <= req_d;
    end
  end

  always_ff @(posedge core_clk_i) begin
    ack_s1_q <= ack_tgl;
    ack_s2_q <= ack_s1_q;
    dn_s1_q  <= done_tgl;
    dn_s2_q  <= dn_s1_q;
    dn_s3_q  <= dn_s2_q;
  end

  assign read_done = dn_s2_q ^ dn_s3_q;

  status_serial_link #(
    .DEV_ADDR (DEV_ADDR)
  ) u_link (
    .scl_i           (scl_i),
    .rst_n_i         (rst_n_i),
    .sda_i           (sda_i),
    .sda_o           (sda_o),
    .sda_oe_o        (sda_oe_o),
    .status0_i       (pub0_q),
    .status1_i       (pub1_q),
    .snap_req_i      (req_q),
    .snap_ack_o      (ack_tgl),
    .read_done_tgl_o (done_tgl)
  );

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence oc_arrive0;
    $rose(oc_q[0]);
  endsequence

  off_when_disabled_a: assert property (!channel_on_bit_i[0] |=> off_q[0])
    else $error("channel 0 disabled but output-off clear");
  pump_low_off_a: assert property (pump_low_s[0] |=> !pump_ok_q[0] && off_q[0])
    else $error("low pump not reported or output left on");
  oc_after_tdis_a: assert property (oc_arrive0 |-> $past(oc_due[0]) ##1 off_q[0])
    else $error("overcurrent set early or output not forced off");
  pbad_window_a: assert property (channel_on_bit_i[1] && far_s[1] |=> pbad_q[1])
    else $error("power-bad not set outside window");
  tone_select_a: assert property (tone_tx_select_i[0] && txv_s[0] |=> tone_q[0])
    else $error("transmit tone threshold not used");
  therm_off_a: assert property (therm_q |=> &off_q)
    else $error("thermal trip did not force both outputs off");
  uv_latched_a: assert property (uv_q && !read_done |=> uv_q)
    else $error("undervolt flag dropped without a read");
  boost_hyst_a: assert property (bst_q[1] && !bst_dn_s[1] |=> bst_q[1])
    else $error("boost-high cleared above lower threshold");
  epf_delay_a: assert property ($fell(epf_q) |-> $past(epf_due) && $past(fail_rec_s))
    else $error("early-fail cleared before the selected delay");
  retry_step_a: assert property (restart_policy_i && $fell(oc_q[1]) |-> $past(retry_tick))
    else $error("overcurrent auto-cleared off the retry tick");
  irq_release_a: assert property (read_done && !set_evt |=> irq_n_o)
    else $error("interrupt held after a completed read");
  irq_pull_a: assert property (set_evt |=> !irq_n_o ##1 (!irq_n_o || $past(read_done)))
    else $error("interrupt not pulled low on new fault");

endmodule

// file: verification/serial_host_model.sv
// behavioural two-wire host that polls the status bytes
`timescale 1ns/10ps
module serial_host_model
  import lnb_status_pkg::*;
(
  output logic      scl_o,
  output logic      sda_pull_o,
  input  wire logic sda_i
);
  localparam time HALF = 6ns;

  initial begin
    scl_o      = 1'b1;
    sda_pull_o = 1'b0;
  end

  // data only moves while the clock is low; sampled at the rising edge
  task automatic pulse(output logic smp);
    #(HALF/2) scl_o = 1'b1;
    smp = sda_i;
    #HALF scl_o = 1'b0;
    // the link looks at data on the falling edge too, so data moves a quarter period later
    #(HALF/2);
  endtask

  // the link resets only while its clock runs, so reset needs these
  task automatic pulses(input int n);
    logic s;
    repeat (n) pulse(s);
    #HALF scl_o = 1'b1;
  endtask

  task automatic start;
    sda_pull_o = 1'b0;
    #HALF scl_o = 1'b1;
    #HALF sda_pull_o = 1'b1;
    #HALF scl_o = 1'b0;
    #(HALF/2);
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      sda_pull_o = ~b[i];
      pulse(s);
    end
    sda_pull_o = 1'b0;
    pulse(s);
    ack = (s === 1'b0);
  endtask

  task automatic recv_byte(input logic last, output logic [7:0] d);
    logic s;
    sda_pull_o = 1'b0;
    for (int i = 7; i >= 0; i--) pulse(d[i]);
    sda_pull_o = ~last;
    pulse(s);
    sda_pull_o = 1'b0;
  endtask

  // a complete, acknowledged read is what lets latched flags clear
  task automatic read_status(input logic ptr, output logic [7:0] d, output logic ok);
    logic a1, a2, a3;
    // idle clocks let the link leave reset, forget the last stop and refresh its status copy
    pulses(16);
    start();
    send_byte({DEV_ADDR_DEF, 1'b0}, a1);
    send_byte({7'h00, ptr}, a2);
    start();
    send_byte({DEV_ADDR_DEF, 1'b1}, a3);
    recv_byte(1'b1, d);
    sda_pull_o = 1'b1;
    #HALF scl_o = 1'b1;
    #HALF sda_pull_o = 1'b0;
    ok = a1 & a2 & a3;
  endtask
endmodule

// file: verification/tb_lnb_fault_status_irq.sv
// self-checking bench for the fault/status flags, interrupt and serial read path
`timescale 1ns/10ps
module tb_lnb_fault_status_irq;
  import lnb_status_pkg::*;
  localparam int RETRY = 50;
  logic       core_clk_i, rst_n_i, scl_i, sda_i, sda_o, sda_oe_o, host_pull;
  logic       vin_low_i, vreg_low_i, overtemp_i, fail_warn_i, fail_recovered_i;
  logic [1:0] over_limit_i, pump_low_i, out_outside_wide_i, out_inside_narrow_i;
  logic [1:0] tone_xmt_valid_i, tone_rcv_valid_i, boost_above_set_i, boost_below_clr_i;
  logic [1:0] channel_on_bit_i, tone_tx_select_i, output_off_flag_o;
  logic       restart_policy_i, fail_delay_sel_low_i, fail_delay_sel_high_i;
  logic       factory_lock_flag_i, irq_n_o;
  logic [7:0] status0_o, status1_o, d;
  int         n_errors, num_checks, n;
  int         dly[4] = '{0, 10, 20, 30};

  // open-drain data line with pull-up
  assign sda_i = ~((sda_oe_o & ~sda_o) | host_pull);

  lnb_fault_status_irq #(.RETRY_CYCLES(RETRY), .EPF_CYCLES1(10), .EPF_CYCLES2(20),
    .EPF_CYCLES3(30), .TDIS_CYCLES(5)) lnb_fault_status_irq_i (
    .core_clk_i, .rst_n_i, .scl_i, .sda_i, .sda_o, .sda_oe_o, .vin_low_i, .vreg_low_i,
    .overtemp_i, .fail_warn_i, .fail_recovered_i, .over_limit_i, .pump_low_i,
    .out_outside_wide_i, .out_inside_narrow_i, .tone_xmt_valid_i, .tone_rcv_valid_i,
    .boost_above_set_i, .boost_below_clr_i, .channel_on_bit_i, .tone_tx_select_i,
    .restart_policy_i, .fail_delay_sel_low_i, .fail_delay_sel_high_i,
    .factory_lock_flag_i, .output_off_flag_o, .status0_o, .status1_o, .irq_n_o);

  serial_host_model serial_host_model_i (.scl_o(scl_i), .sda_pull_o(host_pull), .sda_i(sda_i));

  initial begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end

  task automatic cyc(input int k);
    repeat (k) @(negedge core_clk_i);
  endtask

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rd(input logic p);
    logic ok;
    serial_host_model_i.read_status(p, d, ok);
    check("read_ack", {7'h00, ok}, 8'h01);
    cyc(5);
  endtask

  task automatic report_and_stop;
    if (n_errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    #1ms;
    n_errors++;
    report_and_stop();
  end

  initial begin
    {rst_n_i, vin_low_i, vreg_low_i, overtemp_i, fail_warn_i, fail_recovered_i} = '0;
    {over_limit_i, pump_low_i, out_outside_wide_i, out_inside_narrow_i} = '0;
    {tone_xmt_valid_i, tone_rcv_valid_i, boost_above_set_i, boost_below_clr_i} = '0;
    {channel_on_bit_i, tone_tx_select_i, restart_policy_i} = '0;
    {fail_delay_sel_low_i, fail_delay_sel_high_i} = '0;
    factory_lock_flag_i = 1'b1;
    n_errors = 0;
    num_checks = 0;
    serial_host_model_i.pulses(8);
    cyc(3);
    rst_n_i = 1'b1;
    cyc(5);
    check("rst_status0", status0_o, 8'h03);
    check("rst_irq", irq_n_o, 8'h01);
    channel_on_bit_i = 2'b11;
    out_inside_narrow_i = 2'b11;
    cyc(5);
    check("on_status0", status0_o, 8'h00);
    check("on_status1", status1_o, 8'h23);
    // overcurrent, latched policy
    over_limit_i = 2'b01;
    cyc(5);
    check("oc_early", status0_o, 8'h00);
    cyc(8);
    check("oc_set", status0_o, 8'h05);
    check("oc_irq", irq_n_o, 8'h00);
    rd(1'b0);
    check("oc_byte", d, 8'h05);
    check("oc_kept", status0_o, 8'h05);
    check("oc_irq_rel", irq_n_o, 8'h01);
    over_limit_i = 2'b00;
    cyc(5);
    check("oc_latched", status0_o, 8'h05);
    rd(1'b0);
    check("oc_clear", status0_o, 8'h00);
    check("oc_off", output_off_flag_o, 8'h00);
    // undervoltage from either monitor
    for (int j = 0; j < 2; j++) begin
      {vreg_low_i, vin_low_i} = 2'(1 << j);
      cyc(5);
      check("uv_set", status0_o, 8'h43);
      check("uv_irq", irq_n_o, 8'h00);
      {vreg_low_i, vin_low_i} = 2'b00;
      cyc(5);
      check("uv_latched", status0_o, 8'h43);
      rd(1'b0);
      check("uv_clear", status0_o, 8'h00);
    end
    // auto-retry of thermal and overcurrent
    restart_policy_i = 1'b1;
    overtemp_i = 1'b1;
    over_limit_i = 2'b10;
    cyc(15);
    check("retry_set", status0_o, 8'h8b);
    cyc(RETRY + 10);
    check("retry_hold", status0_o, 8'h8b);
    overtemp_i = 1'b0;
    over_limit_i = 2'b00;
    cyc(RETRY + 15);
    check("retry_clr", status0_o, 8'h00);
    rd(1'b0);
    restart_policy_i = 1'b0;
    // pump, power-bad hysteresis, tone and boost
    pump_low_i = 2'b01;
    cyc(5);
    check("pump_low", status1_o[1:0], 8'h02);
    check("pump_off", output_off_flag_o, 8'h01);
    pump_low_i = 2'b00;
    out_outside_wide_i = 2'b10;
    out_inside_narrow_i = 2'b01;
    cyc(5);
    check("pbad_set", status0_o, 8'h20);
    check("pbad_irq", irq_n_o, 8'h01);
    out_outside_wide_i = 2'b00;
    cyc(5);
    check("pbad_hyst", status0_o, 8'h20);
    out_inside_narrow_i = 2'b11;
    cyc(5);
    check("pbad_clr", status0_o, 8'h00);
    tone_tx_select_i = 2'b01;
    tone_xmt_valid_i = 2'b01;
    cyc(5);
    check("tone_xmt", status1_o[2], 8'h01);
    tone_tx_select_i = 2'b00;
    cyc(5);
    check("tone_rcv0", status1_o[2], 8'h00);
    tone_rcv_valid_i = 2'b01;
    cyc(5);
    check("tone_rcv1", status1_o[2], 8'h01);
    boost_above_set_i = 2'b10;
    cyc(5);
    check("boost_set", status1_o[7:6], 8'h02);
    check("boost_irq", irq_n_o, 8'h01);
    boost_above_set_i = 2'b00;
    cyc(5);
    check("boost_hold", status1_o[7:6], 8'h02);
    boost_below_clr_i = 2'b10;
    cyc(5);
    check("boost_clr", status1_o[7:6], 8'h00);
    // early fail with every delay code
    for (int k = 0; k < 4; k++) begin
      {fail_delay_sel_high_i, fail_delay_sel_low_i} = 2'(k);
      fail_warn_i = 1'b1;
      fail_recovered_i = 1'b0;
      cyc(5);
      check("epf_set", status1_o[S1_EPF_BIT], 8'h01);
      check("epf_irq", irq_n_o, 8'h00);
      fail_warn_i = 1'b0;
      fail_recovered_i = 1'b1;
      n = 0;
      while (status1_o[S1_EPF_BIT] !== 1'b0 && n < 100) begin
        cyc(1);
        n++;
      end
      check("epf_delay", {7'h00, n >= dly[k] && n <= dly[k] + 6}, 8'h01);
      rd(1'b1);
      check("epf_byte1", d, 8'h27);
      check("epf_irq_rel", irq_n_o, 8'h01);
    end
    report_and_stop();
  end
endmodule
